// ==== slp_checksum.sv ====
// Per-lane checksum of the link parameters, sum modulo 256
`timescale 1ns/100ps
`default_nettype none
module slp_checksum (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Parameter fields
   input  wire logic [7:0] lane_ident,
   input  wire logic [7:0] param_sum,
   // Result
   output logic [7:0]      checksum_q
);
   import slp_pkg::*;

   logic [7:0] checksum_d;
   assign checksum_d = param_sum + lane_ident;

   // Registered so the readback is glitch free
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         checksum_q <= SLP_READ_ZERO;
      end else begin
         checksum_q <= checksum_d;
      end
   end
endmodule : slp_checksum
`default_nettype wire

// ==== slp_host_model.sv ====
// Host model driving the register strobes of the bank
`timescale 1ns/100ps
`default_nettype none
module slp_host_model (
   // Clock
   input  wire logic clk,
   // Register access
   output logic       reg_wr = 1'b0,
   output logic       reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00
);
   // Caller sits just after a rising edge; request is taken at the next one
   task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      // Channel index stays at its default; nothing here writes address zero
      reg_wr    <= w;
      reg_rd    <= r;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask : xfer
   task automatic idle;
      // Released lines flip so a stale value never looks like a request
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
      @(posedge clk);
   endtask : idle
endmodule : slp_host_model
`default_nettype wire

// ==== slp_octets_calc.sv ====
// Octets-per-frame derivation from converter and lane counts
`timescale 1ns/100ps
`default_nettype none
module slp_octets_calc (
   // Link shape
   input  wire logic       two_converters,
   input  wire logic       two_lanes,
   // Derived value
   output logic [7:0]      octets_per_frame
);
   import slp_pkg::*;

   // F = 2*M/L with M and L each one or two; the field holds F-1, so one lane and one converter read 1
   logic [2:0] conv_count;
   logic [2:0] doubled;
   logic [2:0] frame_octets;
   always_comb begin
      conv_count       = two_converters ? 3'h2 : 3'h1;
      doubled          = {conv_count[1:0], 1'b0};
      frame_octets     = two_lanes ? {1'b0, doubled[2:1]} : doubled;
      octets_per_frame = {5'h00, frame_octets - 3'h1};
   end
endmodule : slp_octets_calc
`default_nettype wire

// ==== slp_param_regs.sv ====
// Link-parameter register bank of a two-converter serial transmitter
//
// Operation
// RULE1: Converter resolution field reads a fixed value; writes to it are ignored.
// RULE2: Samples-per-converter-per-frame reads as a constant one.
// RULE3: Dense-packing flag in bit 7 reads as fixed zero.
// RULE4: Control words per frame cycle reads as constant zero.
// RULE5: Two spare bytes are freely writable and readable, reset to zero.
// RULE6: Frames-per-multiframe field is writable, sitting below three unused upper bits.
// RULE7: Host keeps channel index at default before writing port configuration.
// RULE8: Octets per frame is twice converters over lanes, read back minus one.
// RULE9: Lane-control bit selects one lane when clear, two when set.
// RULE10: Scramble-lane register bit 7 high enables scrambling.
// RULE11: Converters register bit 0 selects one converter when clear, two when set.
`timescale 1ns/100ps
`default_nettype none
module slp_param_regs (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Register access from the serial control port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   output logic            reg_rvalid,
   // Link configuration toward the transmitter
   output logic            scramble_enable,
   output logic            two_lanes,
   output logic            two_converters,
   output logic [3:0]      bank_ident,
   output logic [4:0]      lane0_ident,
   output logic [4:0]      lane1_ident,
   output logic [4:0]      frames_per_multiframe,
   output logic [1:0]      ctrl_bits_per_sample
);
   import slp_pkg::*;

   logic [7:0] bank_ident_q;
   logic [7:0] lane0_ident_q;
   logic [7:0] lane1_ident_q;
   logic [7:0] scramble_lane_q;
   logic [7:0] converters_q;
   logic [4:0] frames_mf_q;
   logic [1:0] ctrl_bits_q;
   logic [7:0] spare_a_q;
   logic [7:0] spare_b_q;
   logic [7:0] rdata_d;
   logic [7:0] octets_per_frame;
   logic [7:0] param_sum;
   logic [7:0] lane0_chksum_q;
   logic [7:0] lane1_chksum_q;

   // Open bits are not stored, so they always read back zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bank_ident_q  <= SLP_RST_BANK_IDENT;
         lane0_ident_q <= SLP_RST_LANE0_IDENT;
         lane1_ident_q <= SLP_RST_LANE1_IDENT;
      end else if (reg_wr) begin
         if (reg_addr == SLP_ADDR_BANK_IDENT) begin
            bank_ident_q <= {4'h0, reg_wdata[3:0]};
         end else if (reg_addr == SLP_ADDR_LANE0_IDENT) begin
            lane0_ident_q <= {3'h0, reg_wdata[4:0]};
         end else if (reg_addr == SLP_ADDR_LANE1_IDENT) begin
            lane1_ident_q <= {3'h0, reg_wdata[4:0]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scramble_lane_q <= SLP_RST_SCRAMBLE_LANE;
         converters_q    <= SLP_RST_CONVERTERS;
      end else if (reg_wr) begin
         if (reg_addr == SLP_ADDR_SCRAMBLE_LANE) begin
            // Only scrambler enable and lane control are kept [RULE10] [RULE9]
            scramble_lane_q <= {reg_wdata[SLP_SCRAMBLE_BIT], 6'h00, reg_wdata[SLP_LANE_CTRL_BIT]};
         end else if (reg_addr == SLP_ADDR_CONVERTERS) begin
            converters_q <= {7'h00, reg_wdata[SLP_CONV_CTRL_BIT]}; // [RULE11]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frames_mf_q <= SLP_RST_FRAMES_MF;
         ctrl_bits_q <= SLP_RST_CTRL_BITS;
      end else if (reg_wr) begin
         if (reg_addr == SLP_ADDR_FRAMES_MF) begin
            frames_mf_q <= reg_wdata[4:0]; // [RULE6]
         end else if (reg_addr == SLP_ADDR_RES_CTRL) begin
            // Resolution bits of the write are dropped [RULE1]
            ctrl_bits_q <= reg_wdata[SLP_CTRL_BITS_LSB +: 2];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         spare_a_q <= SLP_RST_SPARE;
         spare_b_q <= SLP_RST_SPARE;
      end else if (reg_wr) begin
         if (reg_addr == SLP_ADDR_SPARE_A) begin
            spare_a_q <= reg_wdata; // [RULE5]
         end else if (reg_addr == SLP_ADDR_SPARE_B) begin
            spare_b_q <= reg_wdata; // [RULE5]
         end
      end
   end

   slp_octets_calc u_octets (
      .two_converters   (converters_q[SLP_CONV_CTRL_BIT]),
      .two_lanes        (scramble_lane_q[SLP_LANE_CTRL_BIT]),
      .octets_per_frame (octets_per_frame)
   ); // [RULE8]

   // Checksum covers the shared parameter fields; lane identity is added per lane
   assign param_sum = bank_ident_q + scramble_lane_q + octets_per_frame + {3'h0, frames_mf_q}
                      + converters_q + {ctrl_bits_q, 1'b0, SLP_RESOLUTION} + {3'h0, SLP_TOTAL_BITS}
                      + {3'h0, SLP_SAMPLES_PER_FRAME} + spare_a_q + spare_b_q;

   slp_checksum u_chk0 (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .lane_ident (lane0_ident_q),
      .param_sum  (param_sum),
      .checksum_q (lane0_chksum_q)
   );

   slp_checksum u_chk1 (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .lane_ident (lane1_ident_q),
      .param_sum  (param_sum),
      .checksum_q (lane1_chksum_q)
   );

   // Read decode; unmapped addresses read zero
   always_comb begin
      rdata_d = SLP_READ_ZERO;
      if (reg_addr == SLP_ADDR_BANK_IDENT) begin
         rdata_d = bank_ident_q;
      end else if (reg_addr == SLP_ADDR_LANE0_IDENT) begin
         rdata_d = lane0_ident_q;
      end else if (reg_addr == SLP_ADDR_LANE1_IDENT) begin
         rdata_d = lane1_ident_q;
      end else if (reg_addr == SLP_ADDR_SCRAMBLE_LANE) begin
         rdata_d = scramble_lane_q;
      end else if (reg_addr == SLP_ADDR_OCTETS_FRAME) begin
         rdata_d = octets_per_frame; // [RULE8]
      end else if (reg_addr == SLP_ADDR_FRAMES_MF) begin
         rdata_d = {3'h0, frames_mf_q}; // [RULE6]
      end else if (reg_addr == SLP_ADDR_CONVERTERS) begin
         rdata_d = converters_q;
      end else if (reg_addr == SLP_ADDR_RES_CTRL) begin
         rdata_d = {ctrl_bits_q, 1'b0, SLP_RESOLUTION}; // [RULE1]
      end else if (reg_addr == SLP_ADDR_TOTAL_BITS) begin
         rdata_d = {3'h0, SLP_TOTAL_BITS};
      end else if (reg_addr == SLP_ADDR_SAMPLES_FRAME) begin
         // Field holds S-1, so zero encodes one sample
         rdata_d = {3'h0, SLP_SAMPLES_PER_FRAME}; // [RULE2]
      end else if (reg_addr == SLP_ADDR_DENSITY_CTRL) begin
         rdata_d = {SLP_DENSE_PACKING, 2'h0, SLP_CTRL_WORDS_PER_FRAME}; // [RULE3] [RULE4]
      end else if (reg_addr == SLP_ADDR_SPARE_A) begin
         rdata_d = spare_a_q;
      end else if (reg_addr == SLP_ADDR_SPARE_B) begin
         rdata_d = spare_b_q;
      end else if (reg_addr == SLP_ADDR_LANE0_CHKSUM) begin
         rdata_d = lane0_chksum_q;
      end else if (reg_addr == SLP_ADDR_LANE1_CHKSUM) begin
         rdata_d = lane1_chksum_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata  <= SLP_READ_ZERO;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata  <= reg_rd ? rdata_d : SLP_READ_ZERO;
         reg_rvalid <= reg_rd;
      end
   end

   // Configuration outputs registered one cycle behind the stored fields
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scramble_enable       <= SLP_RST_SCRAMBLE_LANE[SLP_SCRAMBLE_BIT];
         two_lanes             <= SLP_RST_SCRAMBLE_LANE[SLP_LANE_CTRL_BIT];
         two_converters        <= SLP_RST_CONVERTERS[SLP_CONV_CTRL_BIT];
         bank_ident            <= SLP_RST_BANK_IDENT[3:0];
         lane0_ident           <= SLP_RST_LANE0_IDENT[4:0];
         lane1_ident           <= SLP_RST_LANE1_IDENT[4:0];
         frames_per_multiframe <= SLP_RST_FRAMES_MF;
         ctrl_bits_per_sample  <= SLP_RST_CTRL_BITS;
      end else begin
         scramble_enable       <= scramble_lane_q[SLP_SCRAMBLE_BIT]; // [RULE10]
         two_lanes             <= scramble_lane_q[SLP_LANE_CTRL_BIT]; // [RULE9]
         two_converters        <= converters_q[SLP_CONV_CTRL_BIT]; // [RULE11]
         bank_ident            <= bank_ident_q[3:0];
         lane0_ident           <= lane0_ident_q[4:0];
         lane1_ident           <= lane1_ident_q[4:0];
         frames_per_multiframe <= frames_mf_q;
         ctrl_bits_per_sample  <= ctrl_bits_q;
      end
   end
endmodule : slp_param_regs
`default_nettype wire

// ==== slp_param_regs_monitor.sv ====
// Port checker of the link-parameter register bank
`timescale 1ns/100ps
`default_nettype none
module slp_param_regs_monitor (
   // Clock, reset and register access
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   // Link configuration
   input wire logic       scramble_enable,
   input wire logic       two_lanes,
   input wire logic       two_converters,
   input wire logic [3:0] bank_ident,
   input wire logic [4:0] lane0_ident,
   input wire logic [4:0] lane1_ident,
   input wire logic [4:0] frames_per_multiframe,
   input wire logic [1:0] ctrl_bits_per_sample
);
   import slp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence rd_s(a);
      reg_rd && reg_addr == a;
   endsequence
   res_read_only_a: assert property (rd_s(SLP_ADDR_RES_CTRL) |=> reg_rdata[4:0] == SLP_RESOLUTION)
      else $error("resolution field changed");
   samples_const_a: assert property (rd_s(SLP_ADDR_SAMPLES_FRAME) |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("samples per frame wrong");
   dense_cf_zero_a: assert property (rd_s(SLP_ADDR_DENSITY_CTRL) |=> reg_rdata == 8'h00)
      else $error("density or control words not zero");
   spare_readback_a: assert property (reg_wr && reg_addr == SLP_ADDR_SPARE_A ##1 rd_s(SLP_ADDR_SPARE_A)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("spare byte lost");
   frames_field_a: assert property (reg_wr && reg_addr == SLP_ADDR_FRAMES_MF
      |-> ##2 {3'h0, frames_per_multiframe} == ($past(reg_wdata, 2) & 8'h1F)) else $error("frames field wrong");
   octets_calc_a: assert property (rd_s(SLP_ADDR_OCTETS_FRAME) |=> reg_rdata ==
      (two_converters ? (two_lanes ? 8'h01 : 8'h03) : (two_lanes ? 8'h00 : 8'h01))) else $error("octets wrong");
   scramble_lane_a: assert property (reg_wr && reg_addr == SLP_ADDR_SCRAMBLE_LANE |-> ##2
      scramble_enable == ($past(reg_wdata, 2) >> 7) && two_lanes == ($past(reg_wdata, 2) & 8'h01))
      else $error("scramble or lane control wrong");
   converters_sel_a: assert property (reg_wr && reg_addr == SLP_ADDR_CONVERTERS |-> ##2
      two_converters == ($past(reg_wdata, 2) & 8'h01)) else $error("converter select wrong");
   cover property (reg_wr && reg_rd);
   cover property (rd_s(SLP_ADDR_OCTETS_FRAME) ##1 reg_rdata == 8'h03);
   cover property (reg_wr && reg_addr == SLP_ADDR_RES_CTRL);
endmodule : slp_param_regs_monitor
bind slp_param_regs slp_param_regs_monitor u_slp_param_regs_monitor (.clk(clk), .sys_rst(sys_rst),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .scramble_enable(scramble_enable), .two_lanes(two_lanes),
   .two_converters(two_converters), .bank_ident(bank_ident), .lane0_ident(lane0_ident),
   .lane1_ident(lane1_ident), .frames_per_multiframe(frames_per_multiframe),
   .ctrl_bits_per_sample(ctrl_bits_per_sample));
`default_nettype wire

// ==== slp_param_regs_tb.sv ====
// Self-checking bench of the link-parameter register bank
`timescale 1ns/100ps
`default_nettype none
module slp_param_regs_tb;
   import slp_pkg::*;
   logic            clk = 1'b0;
   logic            sys_rst = 1'b1;
   wire logic       reg_wr, reg_rd, reg_rvalid, scramble_enable, two_lanes, two_converters;
   wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
   wire logic [3:0] bank_ident;
   wire logic [4:0] lane0_ident, lane1_ident, frames_per_multiframe;
   wire logic [1:0] ctrl_bits_per_sample;
   logic [7:0]      exp_q[$];
   logic [7:0]      r, sb, e;
   int              fail_count = 0;
   int              compares = 0;
   int              seed = 53485;
   logic [7:0]      ra[14] = '{8'h65, 8'h66, 8'h67, 8'h6E, 8'h6F, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75,
                               8'h76, 8'h77, 8'h68};
   logic [7:0]      re[14] = '{8'h00, 8'h00, 8'h01, 8'h80, 8'h01, 8'h0F, 8'h00, 8'h0D, 8'h0F, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h00};
   logic [7:0]      rf[14] = '{8'h0F, 8'h1F, 8'h1F, 8'h81, 8'h01, 8'h1F, 8'h01, 8'hCD, 8'h0F, 8'h00, 8'h00,
                               8'hFF, 8'hFF, 8'h00};
   initial begin
      forever #20 clk = ~clk;
   end
   slp_host_model u_slp_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata));
   slp_param_regs u_slp_param_regs (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .scramble_enable(scramble_enable), .two_lanes(two_lanes), .two_converters(two_converters),
      .bank_ident(bank_ident), .lane0_ident(lane0_ident), .lane1_ident(lane1_ident),
      .frames_per_multiframe(frames_per_multiframe), .ctrl_bits_per_sample(ctrl_bits_per_sample));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      u_slp_host_model.xfer(1'b0, 1'b1, a, 8'h00);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_slp_host_model.xfer(1'b1, 1'b0, a, d);
   endtask : wr
   task automatic print_verdict;
      $display("counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   // A read answer with no note pending must still count as a mismatch
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
         chk(reg_rdata, e);
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      chk({scramble_enable, two_lanes, two_converters, frames_per_multiframe}, 8'h8F);
      chk({3'h0, lane0_ident}, 8'h00);
      chk({3'h0, lane1_ident}, 8'h01);
      foreach (ra[i]) rd(ra[i], re[i]);
      $display("test reset values done");
      foreach (ra[i]) wr(ra[i], 8'hFF);
      foreach (ra[i]) rd(ra[i], rf[i]);
      u_slp_host_model.idle();
      chk({bank_ident, 2'h0, ctrl_bits_per_sample}, 8'hF3);
      chk({3'h0, lane0_ident}, 8'h1F);
      chk({3'h0, lane1_ident}, 8'h1F);
      $display("test read-only writes done");
      sb = 8'hFF;
      for (int i = 0; i < 4; i++) begin
         r = 8'($random(seed));
         wr(SLP_ADDR_CONVERTERS, {7'h0, i[0]});
         wr(SLP_ADDR_SCRAMBLE_LANE, {r[7], 6'h0, i[1]});
         wr(SLP_ADDR_FRAMES_MF, ~r);
         wr(SLP_ADDR_SPARE_A, r);
         rd(SLP_ADDR_SPARE_A, r);
         exp_q.push_back(sb);
         u_slp_host_model.xfer(1'b1, 1'b1, SLP_ADDR_SPARE_B, r);
         sb = r;
         rd(SLP_ADDR_OCTETS_FRAME, (i == 1) ? 8'h03 : (i == 2) ? 8'h00 : 8'h01);
         u_slp_host_model.idle();
         u_slp_host_model.idle();
         chk({scramble_enable, two_lanes, two_converters, frames_per_multiframe}, {r[7], i[1], i[0], ~r[4:0]});
      end
      repeat (3) u_slp_host_model.idle();
      chk(8'(exp_q.size()), 8'h00);
      $display("test link shape done");
      print_verdict();
   end
   initial begin
      repeat (2000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
endmodule : slp_param_regs_tb
`default_nettype wire

// ==== slp_pkg.sv ====
// Package of register offsets, fields and reset values for the link-parameter bank
package slp_pkg;
   localparam logic [7:0] SLP_ADDR_BANK_IDENT     = 8'h65;
   localparam logic [7:0] SLP_ADDR_LANE0_IDENT    = 8'h66;
   localparam logic [7:0] SLP_ADDR_LANE1_IDENT    = 8'h67;
   localparam logic [7:0] SLP_ADDR_SCRAMBLE_LANE  = 8'h6E;
   localparam logic [7:0] SLP_ADDR_OCTETS_FRAME   = 8'h6F;
   localparam logic [7:0] SLP_ADDR_FRAMES_MF      = 8'h70;
   localparam logic [7:0] SLP_ADDR_CONVERTERS     = 8'h71;
   localparam logic [7:0] SLP_ADDR_RES_CTRL       = 8'h72;
   localparam logic [7:0] SLP_ADDR_TOTAL_BITS     = 8'h73;
   localparam logic [7:0] SLP_ADDR_SAMPLES_FRAME  = 8'h74;
   localparam logic [7:0] SLP_ADDR_DENSITY_CTRL   = 8'h75;
   localparam logic [7:0] SLP_ADDR_SPARE_A        = 8'h76;
   localparam logic [7:0] SLP_ADDR_SPARE_B        = 8'h77;
   localparam logic [7:0] SLP_ADDR_LANE0_CHKSUM   = 8'h78;
   localparam logic [7:0] SLP_ADDR_LANE1_CHKSUM   = 8'h79;

   localparam logic [7:0] SLP_RST_BANK_IDENT      = 8'h00;
   localparam logic [7:0] SLP_RST_LANE0_IDENT     = 8'h00;
   localparam logic [7:0] SLP_RST_LANE1_IDENT     = 8'h01;
   localparam logic [7:0] SLP_RST_SCRAMBLE_LANE   = 8'h80;
   localparam logic [7:0] SLP_RST_CONVERTERS      = 8'h00;
   localparam logic [4:0] SLP_RST_FRAMES_MF       = 5'h0F;
   localparam logic [1:0] SLP_RST_CTRL_BITS       = 2'h0;
   localparam logic [7:0] SLP_RST_SPARE           = 8'h00;

   localparam logic [3:0] SLP_BANK_IDENT_MASK_W   = 4'hF;
   localparam int         SLP_SCRAMBLE_BIT        = 7;
   localparam int         SLP_LANE_CTRL_BIT       = 0;
   localparam int         SLP_CONV_CTRL_BIT       = 0;
   localparam int         SLP_CTRL_BITS_LSB       = 6;
   localparam int         SLP_DENSE_BIT           = 7;

   localparam logic [4:0] SLP_RESOLUTION          = 5'h0D;
   localparam logic [4:0] SLP_TOTAL_BITS          = 5'h0F;
   localparam logic [4:0] SLP_SAMPLES_PER_FRAME   = 5'h00;
   localparam logic       SLP_DENSE_PACKING       = 1'b0;
   localparam logic [4:0] SLP_CTRL_WORDS_PER_FRAME = 5'h00;
   localparam logic [7:0] SLP_READ_ZERO           = 8'h00;
endpackage : slp_pkg
